//--- logic/clk_mgr_pkg.sv
// Package for the clock manager: register map, field layout, reset values,
// counts and the packed state carried by the register block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
//
// Summary of operation
// - System clock status shows processor clock at bit 0, output clocks at 8-10.
// - Bit 7 of system clock status shows the USB port clock running.
// - Writing 1 to an output clock bit of the disable register stops it.
// - Each output clock status bit reads 1 while enabled, 0 while disabled.
// - Writing 1 to peripheral enable bit x (2..13 by default) switches that clock on.
// - Writing 1 to peripheral disable bit x switches that clock off.
// - Peripheral status bit x reads 1 when that clock is on.
// - Writes to unimplemented peripheral bits change nothing at all.
// - With oscillator enabled and bypass clear, stable flag sets only after the start-up time.
// - Setting bypass sets the oscillator stable flag at once.
// - With enable and bypass both clear, the stable flag is cleared.
// - Start-up field bits 15..8 give the wait as value times 8 slow cycles.
// - Frequency field holds main clock cycles counted over 16 slow periods.
// - Frequency valid bit 16 reads 1 only when a measurement is available.
// - Divider field: 0 gives no output, 1 bypasses, 2..255 divide.
// - After a PLL write, lock sets after the lock count of slow cycles.
// - Multiplier 0 stops the PLL; otherwise output is input times field plus one.
// - USB divider bits 29..28: pass, divide by 2, divide by 4, reserved.
// - Status register shows oscillator stable at bit 0 and lock at bit 2.

package clk_mgr_pkg;

  // Byte offsets of the register map
  localparam logic [7:0] OFF_SYS_ENABLE = 8'h00;
  localparam logic [7:0] OFF_SYS_DISABLE = 8'h04;
  localparam logic [7:0] OFF_SYS_STATUS = 8'h08;
  localparam logic [7:0] OFF_PER_ENABLE = 8'h10;
  localparam logic [7:0] OFF_PER_DISABLE = 8'h14;
  localparam logic [7:0] OFF_PER_STATUS = 8'h18;
  localparam logic [7:0] OFF_OSC_CTRL = 8'h20;
  localparam logic [7:0] OFF_MAIN_FREQ = 8'h24;
  localparam logic [7:0] OFF_PLL_CFG = 8'h2C;
  localparam logic [7:0] OFF_MGR_STATUS = 8'h68;

  // Field positions
  localparam int CPU_BIT = 0;
  localparam int USB_BIT = 7;
  localparam int PCK_LSB = 8;
  localparam int NUM_PCK = 3;
  localparam int OSC_EN_BIT = 0;
  localparam int OSC_SKIP_BIT = 1;
  localparam int OSC_CNT_LSB = 8;
  localparam int FREQ_VALID_BIT = 16;
  localparam int DIV_LSB = 0;
  localparam int LOCK_CNT_LSB = 8;
  localparam int RANGE_LSB = 14;
  localparam int FACTOR_LSB = 16;
  localparam int USB_DIV_LSB = 28;
  localparam int ST_OSC_BIT = 0;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_MCK_BIT = 3;

  // Reset values and counts
  localparam logic [31:0] PLL_CFG_RESET = 32'h0000_3F00;
  localparam logic [31:0] PERIPH_IMPL_DEFAULT = 32'h0000_3FFC;
  localparam int OSC_CNT_MULT_LOG2 = 3;
  localparam logic [4:0] MEAS_PERIODS = 5'h10;

  typedef enum logic [1:0] {
    OSC_OFF = 2'b00,
    OSC_WAIT = 2'b01,
    OSC_STABLE = 2'b10
  } osc_mode_t;

  // Whole state of the clock manager
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic cpu_on;
    logic usb_on;
    logic [2:0] pck_on;
    logic [31:0] periph;
    logic osc_en;
    logic osc_skip;
    logic [7:0] osc_cnt;
    osc_mode_t osc_mode;
    logic [10:0] osc_left;
    logic osc_stable;
    logic slow_q;
    logic main_q;
    logic [4:0] meas_ticks;
    logic [15:0] meas_cnt;
    logic [15:0] freq;
    logic freq_valid;
    logic [31:0] pll_cfg;
    logic [5:0] lock_left;
    logic lock;
    logic pll_running;
    logic usb_clk_running;
  } state_t;

endpackage

//--- logic/clock_manager.sv
// Clock manager register block: system and peripheral clock gates,
// main oscillator start-up, main clock measurement and PLL lock timing.
// Assumes slow_clk_i and main_clk_i are synchronous levels sampled by
// sys_clk_i; main clock measurement needs main_clk_i below half of sys_clk_i.
`timescale 1ns/1ps

module clock_manager #(
  parameter logic [31:0] PERIPH_IMPL = clk_mgr_pkg::PERIPH_IMPL_DEFAULT
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic slow_clk_i,
  input wire logic main_clk_i,
  output logic cpu_clock_on_o,
  output logic usb_port_clock_on_o,
  output logic [2:0] prog_clock_out_on_o,
  output logic [31:0] periph_clock_bit_o,
  output logic osc_power_on_o,
  output logic osc_stable_flag_o,
  output logic [7:0] pll_div_o,
  output logic [10:0] pll_factor_o,
  output logic [1:0] usb_clock_scaler_o,
  output logic pll_running_o,
  output logic pll_lock_o,
  output logic usb_48m_clock_o
);

  clk_mgr_pkg::state_t st;
  clk_mgr_pkg::state_t next_st;

  logic req;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] wd;
  logic slow_tick;
  logic main_edge;
  logic [5:0] word;

  // Bus request decode and byte-lane mask
  assign req = cyc_i && stb_i && !st.ack;
  assign wr = req && we_i;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wd = dat_i & wmask;
  assign word = adr_i[7:2];
  assign slow_tick = slow_clk_i && !st.slow_q;
  assign main_edge = main_clk_i && !st.main_q;

  // Next-state logic
  always_comb
  begin
    next_st = st;
    next_st.ack = req;
    next_st.slow_q = slow_clk_i;
    next_st.main_q = main_clk_i;

    // Oscillator start-up sequence
    case (st.osc_mode)
      clk_mgr_pkg::OSC_OFF:
      begin
        next_st.osc_stable = 1'b0;
      end
      clk_mgr_pkg::OSC_WAIT:
      begin
        if (st.osc_left == 11'h000)
        begin
          next_st.osc_mode = clk_mgr_pkg::OSC_STABLE;
          next_st.osc_stable = 1'b1;
        end
        else if (slow_tick)
        begin
          next_st.osc_left = st.osc_left - 11'h001;
        end
      end
      clk_mgr_pkg::OSC_STABLE:
      begin
        next_st.osc_stable = 1'b1;
      end
      default:
      begin
        next_st.osc_mode = clk_mgr_pkg::OSC_OFF;
        next_st.osc_stable = 1'b0;
      end
    endcase

    // Main clock measurement over a fixed number of slow periods
    if (st.osc_stable)
    begin
      if (main_edge && st.meas_ticks != 5'h00)
      begin
        next_st.meas_cnt = st.meas_cnt + 16'h0001;
      end
      if (slow_tick)
      begin
        if (st.meas_ticks == clk_mgr_pkg::MEAS_PERIODS)
        begin
          next_st.freq = st.meas_cnt;
          next_st.freq_valid = 1'b1;
          next_st.meas_ticks = 5'h01;
          next_st.meas_cnt = 16'h0000;
        end
        else
        begin
          next_st.meas_ticks = st.meas_ticks + 5'h01;
        end
      end
    end
    else
    begin
      next_st.meas_ticks = 5'h00;
      next_st.meas_cnt = 16'h0000;
    end

    // PLL lock wait on the slow clock
    if (!st.lock)
    begin
      if (st.lock_left == 6'h00)
      begin
        next_st.lock = 1'b1;
      end
      else if (slow_tick)
      begin
        next_st.lock_left = st.lock_left - 6'h01;
      end
    end

    // Derived PLL and USB clock state
    next_st.pll_running = (st.pll_cfg[clk_mgr_pkg::FACTOR_LSB +: 11] != 11'h000)
      && (st.pll_cfg[clk_mgr_pkg::DIV_LSB +: 8] != 8'h00);
    next_st.usb_clk_running = st.usb_on && st.pll_running && st.lock
      && (st.pll_cfg[clk_mgr_pkg::USB_DIV_LSB +: 2] != 2'b11);

    // Register writes
    if (wr)
    begin
      case (word)
        clk_mgr_pkg::OFF_SYS_ENABLE[7:2]:
        begin
          next_st.cpu_on = st.cpu_on | wd[clk_mgr_pkg::CPU_BIT];
          next_st.usb_on = st.usb_on | wd[clk_mgr_pkg::USB_BIT];
          next_st.pck_on = st.pck_on | wd[clk_mgr_pkg::PCK_LSB +: 3];
        end
        clk_mgr_pkg::OFF_SYS_DISABLE[7:2]:
        begin
          next_st.cpu_on = st.cpu_on & ~wd[clk_mgr_pkg::CPU_BIT];
          next_st.usb_on = st.usb_on & ~wd[clk_mgr_pkg::USB_BIT];
          next_st.pck_on = st.pck_on & ~wd[clk_mgr_pkg::PCK_LSB +: 3];
        end
        clk_mgr_pkg::OFF_PER_ENABLE[7:2]:
        begin
          next_st.periph = st.periph | (wd & PERIPH_IMPL);
        end
        clk_mgr_pkg::OFF_PER_DISABLE[7:2]:
        begin
          next_st.periph = st.periph & ~(wd & PERIPH_IMPL);
        end
        clk_mgr_pkg::OFF_OSC_CTRL[7:2]:
        begin
          if (sel_i[0])
          begin
            next_st.osc_en = dat_i[clk_mgr_pkg::OSC_EN_BIT];
            next_st.osc_skip = dat_i[clk_mgr_pkg::OSC_SKIP_BIT];
          end
          if (sel_i[1])
          begin
            next_st.osc_cnt = dat_i[clk_mgr_pkg::OSC_CNT_LSB +: 8];
          end
          if (next_st.osc_skip)
          begin
            next_st.osc_mode = clk_mgr_pkg::OSC_STABLE;
            next_st.osc_stable = 1'b1;
          end
          else if (next_st.osc_en)
          begin
            if (st.osc_skip || !st.osc_en)
            begin
              next_st.osc_mode = clk_mgr_pkg::OSC_WAIT;
              next_st.osc_stable = 1'b0;
              next_st.freq_valid = 1'b0;
              next_st.osc_left = {next_st.osc_cnt, 3'b000};
            end
          end
          else
          begin
            next_st.osc_mode = clk_mgr_pkg::OSC_OFF;
            next_st.osc_stable = 1'b0;
            next_st.freq_valid = 1'b0;
            next_st.freq = 16'h0000;
            next_st.meas_ticks = 5'h00;
            next_st.meas_cnt = 16'h0000;
          end
        end
        clk_mgr_pkg::OFF_PLL_CFG[7:2]:
        begin
          next_st.pll_cfg = (st.pll_cfg & ~wmask) | wd;
          next_st.lock = 1'b0;
          next_st.lock_left = next_st.pll_cfg[clk_mgr_pkg::LOCK_CNT_LSB +: 6];
        end
        default:
        begin
          next_st.rdata = st.rdata;
        end
      endcase
    end

    // Read data, sampled in the cycle the request is taken
    next_st.rdata = 32'h0000_0000;
    if (req && !we_i)
    begin
      case (word)
        clk_mgr_pkg::OFF_SYS_STATUS[7:2]:
        begin
          next_st.rdata[clk_mgr_pkg::CPU_BIT] = st.cpu_on;
          next_st.rdata[clk_mgr_pkg::USB_BIT] = st.usb_clk_running;
          next_st.rdata[clk_mgr_pkg::PCK_LSB +: 3] = st.pck_on;
        end
        clk_mgr_pkg::OFF_PER_STATUS[7:2]:
        begin
          next_st.rdata = st.periph;
        end
        clk_mgr_pkg::OFF_OSC_CTRL[7:2]:
        begin
          next_st.rdata[clk_mgr_pkg::OSC_EN_BIT] = st.osc_en;
          next_st.rdata[clk_mgr_pkg::OSC_SKIP_BIT] = st.osc_skip;
          next_st.rdata[clk_mgr_pkg::OSC_CNT_LSB +: 8] = st.osc_cnt;
        end
        clk_mgr_pkg::OFF_MAIN_FREQ[7:2]:
        begin
          next_st.rdata[15:0] = st.freq;
          next_st.rdata[clk_mgr_pkg::FREQ_VALID_BIT] = st.freq_valid;
        end
        clk_mgr_pkg::OFF_PLL_CFG[7:2]:
        begin
          next_st.rdata = st.pll_cfg;
        end
        clk_mgr_pkg::OFF_MGR_STATUS[7:2]:
        begin
          next_st.rdata[clk_mgr_pkg::ST_OSC_BIT] = st.osc_stable;
          next_st.rdata[clk_mgr_pkg::ST_LOCK_BIT] = st.lock;
          next_st.rdata[clk_mgr_pkg::ST_MCK_BIT] = 1'b1;
        end
        default:
        begin
          next_st.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.cpu_on <= 1'b1;
      st.pll_cfg <= clk_mgr_pkg::PLL_CFG_RESET;
      st.lock_left <= clk_mgr_pkg::PLL_CFG_RESET[clk_mgr_pkg::LOCK_CNT_LSB +: 6];
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign dat_o = st.rdata;
  assign ack_o = st.ack;
  assign cpu_clock_on_o = st.cpu_on;
  assign usb_port_clock_on_o = st.usb_on;
  assign prog_clock_out_on_o = st.pck_on;
  assign periph_clock_bit_o = st.periph;
  assign osc_power_on_o = st.osc_en;
  assign osc_stable_flag_o = st.osc_stable;
  assign pll_div_o = st.pll_cfg[clk_mgr_pkg::DIV_LSB +: 8];
  assign pll_factor_o = st.pll_cfg[clk_mgr_pkg::FACTOR_LSB +: 11];
  assign usb_clock_scaler_o = st.pll_cfg[clk_mgr_pkg::USB_DIV_LSB +: 2];
  assign pll_running_o = st.pll_running;
  assign pll_lock_o = st.lock;
  assign usb_48m_clock_o = st.usb_clk_running;

  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  logic wr_q;
  logic [5:0] word_q;
  logic [31:0] wd_q;
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_q <= 1'b0;
      word_q <= 6'h00;
      wd_q <= 32'h0000_0000;
    end
    else
    begin
      wr_q <= wr;
      word_q <= word;
      wd_q <= wd;
    end
  end

  property p_ack_one;
    ack_o |=> !ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

  property p_pck_off;
    wr_q && word_q == clk_mgr_pkg::OFF_SYS_DISABLE[7:2]
      |-> (st.pck_on & wd_q[clk_mgr_pkg::PCK_LSB +: 3]) == 3'b000;
  endproperty
  a_pck_off: assert property (p_pck_off) else $error("output clock not stopped");

  property p_per_on;
    wr_q && word_q == clk_mgr_pkg::OFF_PER_ENABLE[7:2]
      |-> (st.periph & wd_q & PERIPH_IMPL) == (wd_q & PERIPH_IMPL);
  endproperty
  a_per_on: assert property (p_per_on) else $error("peripheral clock not enabled");

  property p_per_off;
    wr_q && word_q == clk_mgr_pkg::OFF_PER_DISABLE[7:2] |-> (st.periph & wd_q) == 32'h0;
  endproperty
  a_per_off: assert property (p_per_off) else $error("peripheral clock not disabled");

  property p_unimpl;
    (st.periph & ~PERIPH_IMPL) == 32'h0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented peripheral bit set");

  property p_osc_wait;
    $rose(st.osc_stable) && !st.osc_skip |-> $past(st.osc_left) == 11'h000;
  endproperty
  a_osc_wait: assert property (p_osc_wait) else $error("stable before start-up done");

  property p_skip;
    st.osc_skip |-> st.osc_stable;
  endproperty
  a_skip: assert property (p_skip) else $error("bypass without stable flag");

  property p_off;
    !st.osc_en && !st.osc_skip |-> !st.osc_stable && !st.freq_valid;
  endproperty
  a_off: assert property (p_off) else $error("stable or valid while off");

  property p_load;
    wr_q && word_q == clk_mgr_pkg::OFF_OSC_CTRL[7:2] && $rose(st.osc_mode == clk_mgr_pkg::OSC_WAIT)
      |-> st.osc_left == {st.osc_cnt, 3'b000};
  endproperty
  a_load: assert property (p_load) else $error("start-up count not times 8");

  property p_valid;
    st.freq_valid |-> st.osc_stable;
  endproperty
  a_valid: assert property (p_valid) else $error("valid without stable oscillator");

  property p_pll_wr;
    wr_q && word_q == clk_mgr_pkg::OFF_PLL_CFG[7:2] |-> !st.lock;
  endproperty
  a_pll_wr: assert property (p_pll_wr) else $error("lock kept across PLL write");

  property p_lock;
    $rose(st.lock) |-> $past(st.lock_left) == 6'h00;
  endproperty
  a_lock: assert property (p_lock) else $error("lock before count expired");

  c_lock: cover property ($rose(st.lock));
  c_freq: cover property ($rose(st.freq_valid));
  c_skip: cover property ($rose(st.osc_skip));
  c_per: cover property (wr && word == clk_mgr_pkg::OFF_PER_ENABLE[7:2]);

endmodule

//--- dv/clock_manager_tb_top.sv
// Self-checking bench for the clock manager register block.
// Assumes the design package is compiled first; slow and main clocks are bench levels.
`timescale 1ns/1ps

module clock_manager_tb_top;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
  } row_t;

  logic sys_clk_i, rst_i, cyc_i, stb_i, we_i, slow_clk_i, main_clk_i;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic ack_o, cpu_on, usb_on, osc_on, stable, running, lock, usb_clk;
  logic [2:0] pck_on;
  logic [31:0] periph;
  logic [7:0] pll_div;
  logic [10:0] factor;
  logic [1:0] scaler;
  logic [7:0] tick;
  int num_errors, checks_done;
  row_t rows [0:15];

  clock_manager u_clock_manager (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .slow_clk_i(slow_clk_i), .main_clk_i(main_clk_i), .cpu_clock_on_o(cpu_on),
    .usb_port_clock_on_o(usb_on), .prog_clock_out_on_o(pck_on),
    .periph_clock_bit_o(periph), .osc_power_on_o(osc_on), .osc_stable_flag_o(stable),
    .pll_div_o(pll_div), .pll_factor_o(factor), .usb_clock_scaler_o(scaler),
    .pll_running_o(running), .pll_lock_o(lock), .usb_48m_clock_o(usb_clk)
  );

  // System clock, 20 ns period
  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // Slow clock period 8 cycles, main clock period 4 cycles
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      tick <= 8'h00;
    else
      tick <= tick + 8'h01;
    slow_clk_i <= tick[2];
    main_clk_i <= tick[1];
  end

  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    chk32(name, {31'h0, exp}, {31'h0, got});
  endtask

  // One classic Wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      num_errors++;
      $display("[FAIL] bus ack expected 1 seen %b", ack_o);
    end
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic slow(input int k);
    repeat (k * 8) @(posedge sys_clk_i);
  endtask

  // Hang guard, about twenty-four times the expected run
  initial
  begin
    #400000;
    num_errors++;
    complete_run();
  end

  initial
  begin
    {cyc_i, stb_i, we_i} = 3'h0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    rst_i = 1'b1;
    // Reset values, system and peripheral gates, unmapped place
    rows = '{
      '{1'b0, clk_mgr_pkg::OFF_SYS_STATUS, 32'h0, 32'hFFFF_FFFF, 32'h0000_0001},
      '{1'b0, clk_mgr_pkg::OFF_PER_STATUS, 32'h0, 32'hFFFF_FFFF, 32'h0},
      '{1'b0, clk_mgr_pkg::OFF_OSC_CTRL, 32'h0, 32'hFFFF_FFFF, 32'h0},
      '{1'b0, clk_mgr_pkg::OFF_MAIN_FREQ, 32'h0, 32'hFFFF_FFFF, 32'h0},
      '{1'b0, clk_mgr_pkg::OFF_PLL_CFG, 32'h0, 32'hFFFF_FFFF, 32'h0000_3F00},
      '{1'b0, 8'h0C, 32'h0, 32'hFFFF_FFFF, 32'h0},
      '{1'b1, clk_mgr_pkg::OFF_SYS_ENABLE, 32'h0000_0700, 32'h0, 32'h0},
      '{1'b0, clk_mgr_pkg::OFF_SYS_STATUS, 32'h0, 32'hFFFF_FF7F, 32'h0000_0701},
      '{1'b1, clk_mgr_pkg::OFF_SYS_DISABLE, 32'h0000_0201, 32'h0, 32'h0},
      '{1'b0, clk_mgr_pkg::OFF_SYS_STATUS, 32'h0, 32'hFFFF_FF7F, 32'h0000_0500},
      '{1'b1, clk_mgr_pkg::OFF_PER_ENABLE, 32'hFFFF_FFFF, 32'h0, 32'h0},
      '{1'b0, clk_mgr_pkg::OFF_PER_STATUS, 32'h0, 32'hFFFF_FFFF, 32'h0000_3FFC},
      '{1'b1, clk_mgr_pkg::OFF_PER_DISABLE, 32'h0000_0111, 32'h0, 32'h0},
      '{1'b0, clk_mgr_pkg::OFF_PER_STATUS, 32'h0, 32'hFFFF_FFFF, 32'h0000_3EEC},
      '{1'b1, 8'h0C, 32'hFFFF_FFFF, 32'h0, 32'h0},
      '{1'b0, clk_mgr_pkg::OFF_MGR_STATUS, 32'h0, 32'h0000_0008, 32'h0000_0008}
    };
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    // Table of ordinary accesses
    foreach (rows[i])
    begin
      wb(rows[i].w, rows[i].a, rows[i].d, q);
      if (!rows[i].w)
        chk32("table read", rows[i].e, q & rows[i].m);
    end
    chk32("periph gates", 32'h0000_3EEC, periph);
    chk32("prog outputs", 32'h0000_0005, {29'h0, pck_on});
    chk1("cpu gate", 1'b0, cpu_on);
    // Oscillator start-up: count 2 gives 16 slow cycles
    wb(1'b1, clk_mgr_pkg::OFF_OSC_CTRL, 32'h0000_0201, q);
    chk1("osc power", 1'b1, osc_on);
    slow(14);
    chk1("stable early", 1'b0, stable);
    slow(4);
    chk1("stable late", 1'b1, stable);
    wb(1'b0, clk_mgr_pkg::OFF_MGR_STATUS, 32'h0, q);
    chk1("status stable", 1'b1, q[0]);
    wb(1'b0, clk_mgr_pkg::OFF_MAIN_FREQ, 32'h0, q);
    chk1("freq valid early", 1'b0, q[16]);
    slow(40);
    wb(1'b0, clk_mgr_pkg::OFF_MAIN_FREQ, 32'h0, q);
    chk32("freq", 32'h0001_0020, q);
    // Both clear, then bypass
    wb(1'b1, clk_mgr_pkg::OFF_OSC_CTRL, 32'h0000_0200, q);
    chk1("osc power off", 1'b0, osc_on);
    slow(1);
    chk1("stable cleared", 1'b0, stable);
    wb(1'b0, clk_mgr_pkg::OFF_MAIN_FREQ, 32'h0, q);
    chk32("freq cleared", 32'h0, q);
    wb(1'b1, clk_mgr_pkg::OFF_OSC_CTRL, 32'h0000_FF02, q);
    @(posedge sys_clk_i);
    chk1("bypass stable", 1'b1, stable);
    // PLL: div 1, count 3, factor 5, USB divide by 2
    wb(1'b1, clk_mgr_pkg::OFF_SYS_ENABLE, 32'h0000_0080, q);
    chk1("usb enable", 1'b1, usb_on);
    wb(1'b1, clk_mgr_pkg::OFF_PLL_CFG, 32'h1005_0301, q);
    chk1("lock cleared", 1'b0, lock);
    slow(1);
    chk1("lock early", 1'b0, lock);
    slow(4);
    chk1("lock", 1'b1, lock);
    chk32("pll fields", {11'h0, 8'h01, 11'h005, 2'h1}, {11'h0, pll_div, factor, scaler});
    chk1("pll running", 1'b1, running);
    chk1("usb clock", 1'b1, usb_clk);
    wb(1'b0, clk_mgr_pkg::OFF_SYS_STATUS, 32'h0, q);
    chk1("usb status", 1'b1, q[7]);
    wb(1'b0, clk_mgr_pkg::OFF_MGR_STATUS, 32'h0, q);
    chk1("status lock", 1'b1, q[2]);
    wb(1'b0, clk_mgr_pkg::OFF_PLL_CFG, 32'h0, q);
    chk32("pll readback", 32'h1005_0301, q);
    wb(1'b1, clk_mgr_pkg::OFF_PLL_CFG, 32'h3005_0301, q);
    slow(5);
    chk1("usb reserved", 1'b0, usb_clk);
    wb(1'b1, clk_mgr_pkg::OFF_PLL_CFG, 32'h0000_0301, q);
    slow(5);
    chk1("factor zero", 1'b0, running);
    wb(1'b1, clk_mgr_pkg::OFF_PLL_CFG, 32'h0005_0300, q);
    slow(5);
    chk1("div zero", 1'b0, running);
    // Bypass to enable: start-up runs again and the old measurement is dropped
    wb(1'b1, clk_mgr_pkg::OFF_OSC_CTRL, 32'h0000_0101, q);
    chk1("stable restart", 1'b0, stable);
    wb(1'b0, clk_mgr_pkg::OFF_MAIN_FREQ, 32'h0, q);
    chk1("freq dropped", 1'b0, q[16]);
    slow(10);
    chk1("stable again", 1'b1, stable);
    // Mid-run reset brings back the reset values
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    chk32("reset gates", 32'h0, periph);
    chk1("reset cpu", 1'b1, cpu_on);
    chk1("reset lock", 1'b0, lock);
    rst_i <= 1'b0;
    wb(1'b0, clk_mgr_pkg::OFF_PLL_CFG, 32'h0, q);
    chk32("reset pll", clk_mgr_pkg::PLL_CFG_RESET, q);
    complete_run();
  end
endmodule
